// ===== include/mpcb_pkg.sv
// constants, attribute codes and request carrier for the mac pib constant bank
package mpcb_pkg;
  // clock and symbol timing
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned SYM_TIME_US = 695;
  localparam int unsigned SYM_CYC     = SYM_TIME_US * 1000 / CLK_NS;
  // interframe spaces in data symbols
  localparam logic [4:0]  IFS_CEN     = 5'h08;
  localparam logic [4:0]  IFS_FCC     = 5'h0a;
  // fixed csma and frame figures
  localparam logic [3:0]  MAX_BE      = 4'h5;
  localparam logic [3:0]  MIN_BE      = 4'h3;
  localparam logic [3:0]  BACKOFF_RST = 4'h8;
  localparam logic [8:0]  MAX_PAYLOAD = 9'h190;
  localparam logic [3:0]  ORDER_RST   = 4'hf;
  localparam logic [23:0] BTX_SAT     = 24'hffffff;
  localparam logic [15:0] SHORT_NONE  = 16'hffff;
  localparam logic [15:0] EUI_FILL    = 16'hfffe;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  // attribute selector codes
  typedef enum logic [4:0] {
    A_ACK_WAIT   = 5'h00, A_ASSOC_PAN  = 5'h01, A_ASSOC_PERM = 5'h02,
    A_AUTO_REQ   = 5'h03, A_BATT_EXT   = 5'h04, A_BATT_PER   = 5'h05,
    A_BCN_PAY    = 5'h06, A_BCN_LEN    = 5'h07, A_BCN_ORDER  = 5'h08,
    A_BTX_TIME   = 5'h09, A_GTS_PERM   = 5'h0a, A_MAX_BE     = 5'h0b,
    A_BACKOFFS   = 5'h0c, A_MAX_FTW    = 5'h0d, A_MIN_BE     = 5'h0e,
    A_MIN_LIFS   = 5'h0f, A_MIN_SIFS   = 5'h10, A_RESP_WAIT  = 5'h11,
    A_RX_IDLE    = 5'h12, A_SEC_EN     = 5'h13, A_SHORT      = 5'h14,
    A_SF_ORDER   = 5'h15, A_SYNC_OFS   = 5'h16, A_TS_SUPP    = 5'h17,
    A_TRANS_PER  = 5'h18, A_EXT_LO     = 5'h19, A_EXT_HI     = 5'h1a,
    A_MAX_PAY    = 5'h1b, A_ZERO_GRP   = 5'h1c
  } mpcb_attr_e;
  localparam int unsigned ATTR_CNT = 29;
  // management request carrier
  typedef struct packed {
    logic        wr;
    logic        rd;
    mpcb_attr_e  attr;
    logic [31:0] wdata;
  } mpcb_req_s;
endpackage : mpcb_pkg

// ===== core/mpcb_bank.sv
// mac pib constant bank: fixed constants, derived waits and writable attributes
//
// Function
// - zero-valued unused mac constants held at zero
// - extended address maps eui-48 into eui-64
// - max payload 400 bytes, longer frames flagged
// - ack wait is rifs plus ack plus cifs
// - response wait equals ack wait
// - associated pan coordinator reads false
// - association permit reads true
// - auto request reads false
// - battery, beacon payload, gts writes have no effect
// - beacon order defaults 15, no effect
// - superframe order stays 15
// - beacon tx time saturates at all ones
// - max backoff exponent fixed at 5
// - max backoffs defaults to 8
// - min backoff exponent fixed at 3
// - max frame total wait held zero
// - lifs and sifs writes have no effect
// - receiver on when idle held true
// - security enabled held true
// - short address ffff when unassigned, associated needs one
// - sync offset, persistence, beacon length held zero
// - timestamp supported held true
// - ifs 8 symbols cenelec a, 10 fcc
// - one data symbol lasts 695 us
`timescale 1ns/1ps
module mpcb_bank #(
  parameter int unsigned SYM_CYC = mpcb_pkg::SYM_CYC
) (
  // clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // management access
  input  wire mpcb_pkg::mpcb_req_s i_req,
  output logic [31:0]            o_rdata,
  output logic                   o_rvalid,
  output logic                   o_wack,
  output logic                   o_bad_attr,
  // device context
  input  wire logic [47:0]       i_eui48,
  input  wire logic              i_band_fcc,
  input  wire logic [15:0]       i_ack_time_us,
  input  wire logic              i_btx_upd,
  input  wire logic [23:0]       i_btx_val,
  input  wire logic              i_assoc_req,
  input  wire logic              i_disassoc,
  input  wire logic [15:0]       i_pay_len,
  // derived values for the mac engine
  output logic [63:0]            o_ext_addr,
  output logic [16:0]            o_ack_wait_us,
  output logic [16:0]            o_resp_wait_us,
  output logic [21:0]            o_ifs_cyc,
  output logic [3:0]             o_max_be,
  output logic [3:0]             o_min_be,
  output logic [3:0]             o_max_backoffs,
  output logic                   o_rx_on_idle,
  output logic                   o_sec_en,
  output logic [15:0]            o_short_addr,
  output logic                   o_associated,
  output logic [23:0]            o_btx_time,
  output logic                   o_len_ok
);
  ////////////////////////////////////////////////////////////////////////////
  // request decode
  wire wr_hit = i_ce & i_req.wr;
  wire rd_hit = i_ce & i_req.rd;
  wire attr_ok = 32'(i_req.attr) < mpcb_pkg::ATTR_CNT;
  wire wr_bo  = wr_hit & (i_req.attr == mpcb_pkg::A_BACKOFFS);
  wire wr_btx = wr_hit & (i_req.attr == mpcb_pkg::A_BTX_TIME);
  wire wr_sa  = wr_hit & (i_req.attr == mpcb_pkg::A_SHORT);
  wire wr_be  = wr_hit & (i_req.attr == mpcb_pkg::A_BATT_EXT);
  wire wr_bp  = wr_hit & (i_req.attr == mpcb_pkg::A_BATT_PER);
  wire wr_bor = wr_hit & (i_req.attr == mpcb_pkg::A_BCN_ORDER);
  wire wr_gts = wr_hit & (i_req.attr == mpcb_pkg::A_GTS_PERM);
  wire wr_lif = wr_hit & (i_req.attr == mpcb_pkg::A_MIN_LIFS);
  wire wr_sif = wr_hit & (i_req.attr == mpcb_pkg::A_MIN_SIFS);

  ////////////////////////////////////////////////////////////////////////////
  // stored attributes; the inert ones only read back, nothing else sees them
  logic [3:0]  backoffs_ff;
  logic [23:0] btx_ff;
  logic [15:0] short_ff;
  logic        assoc_ff;
  logic        batt_ext_ff, gts_ff;
  logic [7:0]  batt_per_ff, lifs_ff, sifs_ff;
  logic [3:0]  bcn_order_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      backoffs_ff  <= mpcb_pkg::BACKOFF_RST;
      batt_ext_ff  <= 1'b0;
      batt_per_ff  <= 8'h00;
      gts_ff       <= 1'b0;
      bcn_order_ff <= mpcb_pkg::ORDER_RST;
      lifs_ff      <= 8'h00;
      sifs_ff      <= 8'h00;
    end else begin
      if (wr_bo)  backoffs_ff  <= i_req.wdata[3:0];
      if (wr_be)  batt_ext_ff  <= i_req.wdata[0];
      if (wr_bp)  batt_per_ff  <= i_req.wdata[7:0];
      if (wr_gts) gts_ff       <= i_req.wdata[0];
      if (wr_bor) bcn_order_ff <= i_req.wdata[3:0];
      if (wr_lif) lifs_ff      <= i_req.wdata[7:0];
      if (wr_sif) sifs_ff      <= i_req.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // beacon tx time: frozen until reset once all ones, from any source
  wire        btx_sat = (btx_ff == mpcb_pkg::BTX_SAT);
  wire [23:0] nxt_btx = wr_btx ? i_req.wdata[23:0] : i_btx_val;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      btx_ff <= 24'h000000;
    end else if (i_ce & ~btx_sat & (wr_btx | i_btx_upd)) begin
      btx_ff <= nxt_btx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short address and association; association is refused without one
  wire sa_none   = (short_ff == mpcb_pkg::SHORT_NONE);
  wire nxt_sa_no = wr_sa ? (i_req.wdata[15:0] == mpcb_pkg::SHORT_NONE) : sa_none;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      short_ff <= mpcb_pkg::SHORT_NONE;
      assoc_ff <= 1'b0;
    end else if (i_ce) begin
      if (wr_sa) short_ff <= i_req.wdata[15:0];
      // dropping the address drops the association in the same edge
      if (i_disassoc | nxt_sa_no) assoc_ff <= 1'b0;
      else if (i_assoc_req)       assoc_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived waits: symbols are turned into microseconds and clock cycles
  wire [4:0]  ifs_sym  = i_band_fcc ? mpcb_pkg::IFS_FCC : mpcb_pkg::IFS_CEN;
  wire [15:0] ifs2_us  = 16'(({1'b0, ifs_sym} << 1) * mpcb_pkg::SYM_TIME_US);
  wire [16:0] ack_wait = {1'b0, ifs2_us} + {1'b0, i_ack_time_us};
  wire [21:0] ifs_cyc  = 22'(ifs_sym * SYM_CYC);
  wire [63:0] eui64    = {i_eui48[47:24], mpcb_pkg::EUI_FILL, i_eui48[23:0]};

  ////////////////////////////////////////////////////////////////////////////
  // read table; fixed entries never depend on any write
  logic [31:0] rd_tbl [0:31];
  genvar gi;
  generate
    for (gi = mpcb_pkg::ATTR_CNT; gi < 32; gi++) begin : g_unmap
      assign rd_tbl[gi] = mpcb_pkg::ZERO_RST;
    end
  endgenerate
  assign rd_tbl[mpcb_pkg::A_ACK_WAIT]   = {15'h0000, ack_wait};
  assign rd_tbl[mpcb_pkg::A_ASSOC_PAN]  = 32'h0000_0000;
  assign rd_tbl[mpcb_pkg::A_ASSOC_PERM] = 32'h0000_0001;
  assign rd_tbl[mpcb_pkg::A_AUTO_REQ]   = 32'h0000_0000;
  assign rd_tbl[mpcb_pkg::A_BATT_EXT]   = {31'h0, batt_ext_ff};
  assign rd_tbl[mpcb_pkg::A_BATT_PER]   = {24'h0, batt_per_ff};
  assign rd_tbl[mpcb_pkg::A_BCN_PAY]    = mpcb_pkg::ZERO_RST;
  assign rd_tbl[mpcb_pkg::A_BCN_LEN]    = mpcb_pkg::ZERO_RST;
  assign rd_tbl[mpcb_pkg::A_BCN_ORDER]  = {28'h0, bcn_order_ff};
  assign rd_tbl[mpcb_pkg::A_BTX_TIME]   = {8'h00, btx_ff};
  assign rd_tbl[mpcb_pkg::A_GTS_PERM]   = {31'h0, gts_ff};
  assign rd_tbl[mpcb_pkg::A_MAX_BE]     = {28'h0, mpcb_pkg::MAX_BE};
  assign rd_tbl[mpcb_pkg::A_BACKOFFS]   = {28'h0, backoffs_ff};
  assign rd_tbl[mpcb_pkg::A_MAX_FTW]    = mpcb_pkg::ZERO_RST;
  assign rd_tbl[mpcb_pkg::A_MIN_BE]     = {28'h0, mpcb_pkg::MIN_BE};
  assign rd_tbl[mpcb_pkg::A_MIN_LIFS]   = {24'h0, lifs_ff};
  assign rd_tbl[mpcb_pkg::A_MIN_SIFS]   = {24'h0, sifs_ff};
  assign rd_tbl[mpcb_pkg::A_RESP_WAIT]  = {15'h0000, ack_wait};
  assign rd_tbl[mpcb_pkg::A_RX_IDLE]    = 32'h0000_0001;
  assign rd_tbl[mpcb_pkg::A_SEC_EN]     = 32'h0000_0001;
  assign rd_tbl[mpcb_pkg::A_SHORT]      = {16'h0000, short_ff};
  assign rd_tbl[mpcb_pkg::A_SF_ORDER]   = {28'h0, mpcb_pkg::ORDER_RST};
  assign rd_tbl[mpcb_pkg::A_SYNC_OFS]   = mpcb_pkg::ZERO_RST;
  assign rd_tbl[mpcb_pkg::A_TS_SUPP]    = 32'h0000_0001;
  assign rd_tbl[mpcb_pkg::A_TRANS_PER]  = mpcb_pkg::ZERO_RST;
  assign rd_tbl[mpcb_pkg::A_EXT_LO]     = eui64[31:0];
  assign rd_tbl[mpcb_pkg::A_EXT_HI]     = eui64[63:32];
  assign rd_tbl[mpcb_pkg::A_MAX_PAY]    = {23'h0, mpcb_pkg::MAX_PAYLOAD};
  assign rd_tbl[mpcb_pkg::A_ZERO_GRP]   = mpcb_pkg::ZERO_RST;
  wire [31:0] rd_sel = rd_tbl[i_req.attr];

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs; a write to a fixed entry is still acknowledged
  logic [31:0] rdata_ff;
  logic        rvalid_ff, wack_ff, bad_ff, len_ok_ff;
  logic [63:0] ext_ff;
  logic [16:0] ack_ff;
  logic [21:0] ifs_cyc_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff   <= mpcb_pkg::ZERO_RST;
      rvalid_ff  <= 1'b0;
      wack_ff    <= 1'b0;
      bad_ff     <= 1'b0;
      ext_ff     <= 64'h0;
      ack_ff     <= 17'h00000;
      ifs_cyc_ff <= 22'h000000;
      len_ok_ff  <= 1'b0;
    end else if (i_ce) begin
      rdata_ff   <= rd_hit ? rd_sel : mpcb_pkg::ZERO_RST;
      rvalid_ff  <= rd_hit;
      wack_ff    <= wr_hit & attr_ok;
      bad_ff     <= (rd_hit | wr_hit) & ~attr_ok;
      ext_ff     <= eui64;
      ack_ff     <= ack_wait;
      ifs_cyc_ff <= ifs_cyc;
      len_ok_ff  <= i_pay_len <= {7'h00, mpcb_pkg::MAX_PAYLOAD};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed csma and receiver figures; flops keep every port registered
  logic [3:0]  max_be_ff, min_be_ff;
  logic        rx_idle_ff, sec_en_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      max_be_ff  <= mpcb_pkg::MAX_BE;
      min_be_ff  <= mpcb_pkg::MIN_BE;
      rx_idle_ff <= 1'b1;
      sec_en_ff  <= 1'b1;
    end else if (i_ce) begin
      max_be_ff  <= mpcb_pkg::MAX_BE;
      min_be_ff  <= mpcb_pkg::MIN_BE;
      rx_idle_ff <= 1'b1;
      sec_en_ff  <= 1'b1;
    end
  end

  assign o_rdata        = rdata_ff;
  assign o_rvalid       = rvalid_ff;
  assign o_wack         = wack_ff;
  assign o_bad_attr     = bad_ff;
  assign o_ext_addr     = ext_ff;
  assign o_ack_wait_us  = ack_ff;
  assign o_resp_wait_us = ack_ff;
  assign o_ifs_cyc      = ifs_cyc_ff;
  assign o_max_be       = max_be_ff;
  assign o_min_be       = min_be_ff;
  assign o_max_backoffs = backoffs_ff;
  assign o_rx_on_idle   = rx_idle_ff;
  assign o_sec_en       = sec_en_ff;
  assign o_short_addr   = short_ff;
  assign o_associated   = assoc_ff;
  assign o_btx_time     = btx_ff;
  assign o_len_ok       = len_ok_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  btx_sat_hold_a: assert property (btx_sat |=> btx_sat)
    else $error("beacon tx time left saturation");
  assoc_has_sa_a: assert property (assoc_ff |-> !sa_none)
    else $error("associated without short address");
  resp_rd_a: assert property (rd_hit && i_req.attr == mpcb_pkg::A_RESP_WAIT |=>
      o_rdata == {15'h0000, o_ack_wait_us})
    else $error("response wait read differs from ack wait");
  ack_sum_a: assert property (i_ce && !i_band_fcc |=>
      o_ack_wait_us == 17'($past(i_ack_time_us)) + 17'd11120)
    else $error("ack wait sum wrong for cenelec a");
  ack_fcc_a: assert property (i_ce && i_band_fcc |=>
      o_ack_wait_us == 17'($past(i_ack_time_us)) + 17'd13900)
    else $error("ack wait sum wrong for fcc");
  fixed_rd_a: assert property (rd_hit && i_req.attr == mpcb_pkg::A_SF_ORDER |=>
      o_rvalid && o_rdata == 32'h0000_000f)
    else $error("superframe order not 15");
  zero_rd_a: assert property (rd_hit && i_req.attr == mpcb_pkg::A_ZERO_GRP |=>
      o_rdata == 32'h0)
    else $error("zero constant group not zero");
  pay_len_a: assert property (i_ce && i_pay_len == 16'd401 |=> !o_len_ok)
    else $error("oversize payload accepted");
  fixed_wr_a: assert property (wr_hit && i_req.attr == mpcb_pkg::A_MAX_BE |=>
      o_wack && o_max_be == 4'h5)
    else $error("fixed write refused or altered");
  ext_map_a: assert property (i_ce |=> o_ext_addr[39:24] == 16'hfffe)
    else $error("eui-64 fill missing");
  bo_rst_a: assert property ($rose(!i_rst) |-> o_max_backoffs == 4'h8 ##1 1)
    else $error("backoffs default not 8");
  rx_sec_a: assert property (o_rx_on_idle && o_sec_en &&
      o_max_be == 4'h5 && o_min_be == 4'h3)
    else $error("fixed csma or receiver output wrong");
  len_ok_a: assert property (i_ce && i_pay_len == 16'd400 |=> o_len_ok)
    else $error("maximum payload refused");
  sa_drop_a: assert property (wr_sa && i_req.wdata[15:0] == 16'hffff |=>
      !o_associated)
    else $error("association kept without short address");
  bad_attr_a: assert property ((rd_hit || wr_hit) && !attr_ok |=>
      o_bad_attr && !o_wack)
    else $error("unknown attribute acknowledged");
  ce_freeze_a: assert property (!i_ce |=>
      $stable(o_max_backoffs) && $stable(o_btx_time))
    else $error("state moved with enable low");

  btx_sat_c: cover property (btx_sat && i_btx_upd);
  assoc_c:   cover property (!assoc_ff ##1 assoc_ff);
  wr_rd_c:   cover property (wr_bo ##1 rd_hit && i_req.attr == mpcb_pkg::A_BACKOFFS);
  ce_frz_c:  cover property (!i_ce && i_req.wr);
endmodule : mpcb_bank

// ===== testbench/mpcb_bank_tb.sv
// self-checking bench for the mac pib constant bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module mpcb_bank_tb;
  // shortened symbol length in clock cycles; o_ifs_cyc then reads ifs times 10
  localparam int unsigned SYM = 10;
  logic                i_clk, i_rst, i_ce, i_band_fcc, i_btx_upd, i_assoc_req, i_disassoc;
  mpcb_pkg::mpcb_req_s i_req;
  logic [47:0]         i_eui48;
  logic [15:0]         i_ack_time_us, i_pay_len;
  logic [23:0]         i_btx_val;
  logic [31:0]         o_rdata;
  logic                o_rvalid, o_wack, o_bad_attr, o_rx_on_idle, o_sec_en;
  logic                o_associated, o_len_ok;
  logic [63:0]         o_ext_addr;
  logic [16:0]         o_ack_wait_us, o_resp_wait_us;
  logic [21:0]         o_ifs_cyc;
  logic [3:0]          o_max_be, o_min_be, o_max_backoffs;
  logic [15:0]         o_short_addr;
  logic [23:0]         o_btx_time;
  int                  num_errors, num_checks, ifs;
  ////////////////////////////////////////////////////////////////////////////////
  mpcb_bank #(.SYM_CYC(SYM)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_wack(o_wack), .o_bad_attr(o_bad_attr), .i_eui48(i_eui48),
    .i_band_fcc(i_band_fcc), .i_ack_time_us(i_ack_time_us), .i_btx_upd(i_btx_upd),
    .i_btx_val(i_btx_val), .i_assoc_req(i_assoc_req), .i_disassoc(i_disassoc),
    .i_pay_len(i_pay_len), .o_ext_addr(o_ext_addr), .o_ack_wait_us(o_ack_wait_us),
    .o_resp_wait_us(o_resp_wait_us), .o_ifs_cyc(o_ifs_cyc), .o_max_be(o_max_be),
    .o_min_be(o_min_be), .o_max_backoffs(o_max_backoffs), .o_rx_on_idle(o_rx_on_idle),
    .o_sec_en(o_sec_en), .o_short_addr(o_short_addr), .o_associated(o_associated),
    .o_btx_time(o_btx_time), .o_len_ok(o_len_ok));
  ////////////////////////////////////////////////////////////////////////////////
  // 200 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // verdict and end of run
  task automatic results;
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // one read; answer is registered on the same edge that takes the request
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_req <= '{wr: 1'b0, rd: 1'b1, attr: mpcb_pkg::mpcb_attr_e'(a), wdata: 32'h0};
    @(posedge i_clk);
    i_req.rd <= 1'b0;
    #1;
    `CHK(o_rvalid, 1'b1)
    `CHK(o_rdata, e)
  endtask : rd
  // one write; k says whether it must be acknowledged or refused
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic k);
    @(posedge i_clk);
    i_req <= '{wr: 1'b1, rd: 1'b0, attr: mpcb_pkg::mpcb_attr_e'(a), wdata: d};
    @(posedge i_clk);
    i_req.wr <= 1'b0;
    #1;
    `CHK(o_wack, k)
    `CHK(o_bad_attr, !k)
  endtask : wr
  // fixed attribute: read, overwrite, read again unchanged
  task automatic cst(input logic [4:0] a, input logic [31:0] e);
    rd(a, e);
    wr(a, ~e, 1'b1);
    rd(a, e);
  endtask : cst
  // beacon tx time update through the hardware path
  task automatic btx(input logic [23:0] v, input logic [23:0] e);
    @(posedge i_clk);
    i_btx_upd <= 1'b1;
    i_btx_val <= v;
    @(posedge i_clk);
    i_btx_upd <= 1'b0;
    #1;
    `CHK(o_btx_time, e)
  endtask : btx
  // association request pulse, then compare the state
  task automatic assoc(input logic e);
    @(posedge i_clk);
    i_assoc_req <= 1'b1;
    @(posedge i_clk);
    i_assoc_req <= 1'b0;
    #1;
    `CHK(o_associated, e)
  endtask : assoc
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #20000;
    num_errors++;
    results();
  end
  // main sequence
  initial begin
    num_errors = 0; num_checks = 0; i_rst = 1'b1; i_ce = 1'b1; i_req = '0;
    i_eui48 = 48'h0a1b2c3d4e5f; i_band_fcc = 1'b0; i_ack_time_us = 16'h0100;
    i_btx_upd = 1'b0; i_btx_val = 24'h0; i_assoc_req = 1'b0; i_disassoc = 1'b0;
    i_pay_len = 16'h0190;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `CHK(o_short_addr, 16'hffff)
    `CHK(o_max_backoffs, 4'h8)
    cst(mpcb_pkg::A_MAX_BE, 32'h5);
    cst(mpcb_pkg::A_MIN_BE, 32'h3);
    cst(mpcb_pkg::A_ASSOC_PAN, 32'h0);
    cst(mpcb_pkg::A_ASSOC_PERM, 32'h1);
    cst(mpcb_pkg::A_AUTO_REQ, 32'h0);
    cst(mpcb_pkg::A_BCN_PAY, 32'h0);
    cst(mpcb_pkg::A_BCN_LEN, 32'h0);
    cst(mpcb_pkg::A_SYNC_OFS, 32'h0);
    cst(mpcb_pkg::A_TRANS_PER, 32'h0);
    cst(mpcb_pkg::A_SF_ORDER, 32'hf);
    cst(mpcb_pkg::A_MAX_FTW, 32'h0);
    cst(mpcb_pkg::A_RX_IDLE, 32'h1);
    cst(mpcb_pkg::A_SEC_EN, 32'h1);
    cst(mpcb_pkg::A_TS_SUPP, 32'h1);
    cst(mpcb_pkg::A_MAX_PAY, 32'h190);
    cst(mpcb_pkg::A_ZERO_GRP, 32'h0);
    rd(mpcb_pkg::A_BATT_EXT, 32'h0);
    rd(mpcb_pkg::A_BATT_PER, 32'h0);
    rd(mpcb_pkg::A_GTS_PERM, 32'h0);
    rd(mpcb_pkg::A_BCN_ORDER, 32'hf);
    // inert writes must leave the fixed csma, receiver and extended address outputs alone
    wr(mpcb_pkg::A_BCN_ORDER, 32'h3, 1'b1);
    wr(mpcb_pkg::A_BATT_EXT, 32'h1, 1'b1);
    wr(mpcb_pkg::A_MIN_LIFS, 32'h55, 1'b1);
    wr(mpcb_pkg::A_MIN_SIFS, 32'h22, 1'b1);
    wr(5'h1d, 32'h1, 1'b0);
    wr(mpcb_pkg::A_BACKOFFS, 32'h3, 1'b1);
    `CHK(o_max_backoffs, 4'h3)
    `CHK({o_max_be, o_min_be, o_rx_on_idle, o_sec_en}, 10'h14f)
    `CHK(o_ext_addr, 64'h0a1b2cfffe3d4e5f)
    rd(mpcb_pkg::A_EXT_LO, 32'hfe3d4e5f);
    rd(mpcb_pkg::A_EXT_HI, 32'h0a1b2cff);
    // reset in mid-run brings back the backoffs default and clears the response flags
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `CHK(o_max_backoffs, 4'h8)
    `CHK({o_rvalid, o_wack, o_bad_attr}, 3'h0)
    // enable low: a write is ignored and nothing is answered
    @(posedge i_clk);
    i_ce  <= 1'b0;
    i_req <= '{wr: 1'b1, rd: 1'b0, attr: mpcb_pkg::A_BACKOFFS, wdata: 32'h1};
    repeat (2) @(posedge i_clk);
    i_req.wr <= 1'b0;
    i_ce     <= 1'b1;
    #1;
    `CHK(o_max_backoffs, 4'h8)
    `CHK(o_wack, 1'b0)
    // both bands: ifs in symbols, symbol in microseconds
    for (int b = 0; b < 2; b++) begin
      @(posedge i_clk);
      i_band_fcc <= b[0];
      ifs = b ? 10 : 8;
      repeat (2) @(posedge i_clk);
      #1;
      `CHK(o_ack_wait_us, 17'(2 * ifs * 695 + 256))
      `CHK(o_resp_wait_us, 17'(2 * ifs * 695 + 256))
      `CHK(o_ifs_cyc, 22'(ifs * SYM))
      rd(mpcb_pkg::A_ACK_WAIT, 32'(2 * ifs * 695 + 256));
      rd(mpcb_pkg::A_RESP_WAIT, 32'(2 * ifs * 695 + 256));
    end
    // payload length boundary
    `CHK(o_len_ok, 1'b1)
    @(posedge i_clk);
    i_pay_len <= 16'h0191;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_len_ok, 1'b0)
    // beacon tx time: management write path, then saturation
    wr(mpcb_pkg::A_BTX_TIME, 32'h00abcd, 1'b1);
    `CHK(o_btx_time, 24'h00abcd)
    btx(24'h123456, 24'h123456);
    btx(24'hffffff, 24'hffffff);
    btx(24'h000000, 24'hffffff);
    wr(mpcb_pkg::A_BTX_TIME, 32'h1, 1'b1);
    rd(mpcb_pkg::A_BTX_TIME, 32'hffffff);
    // association needs a short address first
    assoc(1'b0);
    wr(mpcb_pkg::A_SHORT, 32'h1234, 1'b1);
    `CHK(o_short_addr, 16'h1234)
    assoc(1'b1);
    @(posedge i_clk);
    i_disassoc <= 1'b1;
    @(posedge i_clk);
    i_disassoc <= 1'b0;
    #1;
    `CHK(o_associated, 1'b0)
    assoc(1'b1);
    wr(mpcb_pkg::A_SHORT, 32'hffff, 1'b1);
    `CHK(o_associated, 1'b0)
    rd(mpcb_pkg::A_SHORT, 32'hffff);
    results();
  end
endmodule : mpcb_bank_tb
